// ===== hw/perf_sel_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the event selector
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Mask bit positions are named after the mask value they test
`ifndef PERF_SEL_CFG_SVH
`define PERF_SEL_CFG_SVH

// Register byte addresses
`define ADDR_SELECT 12'h000
`define ADDR_TOTAL 12'h004
`define ADDR_STATUS 12'h008

// Field positions of the select register
`define SEL_CODE_LSB 0
`define SEL_CODE_MSB 11
`define SEL_MASK_LSB 16
`define SEL_MASK_MSB 23
`define SEL_EN_BIT 31

// Field positions of the status register
`define STAT_INC_LSB 0
`define STAT_INC_MSB 3
`define STAT_REV_BIT 8

// Reset values
`define RST_CODE 12'h000
`define RST_MASK 8'h00
`define RST_EN 1'b0
`define RST_TOTAL 32'h0000_0000
`define RST_INC 4'h0
`define RST_WORD 32'h0000_0000

// Event codes
`define EV_DTB_L1_HIT 12'h04D
`define EV_SW_PF_INEFF 12'h052
`define EV_GLOBAL_FLUSH 12'h054
`define EV_MEM_REQ_TYPE 12'h065
`define EV_DATA_PF 12'h067
`define EV_NB_READ_RESP 12'h06C
`define EV_OCTWORD_WR 12'h06D
`define EV_CLK_NOT_HALT 12'h076
`define EV_L2_REQ 12'h07D
`define EV_L2_MISS 12'h07E
`define EV_L2_FILL_WB 12'h07F
`define EV_PAGE_MISMATCH 12'h165
`define EV_IC_FETCH 12'h080
`define EV_IC_MISS 12'h081
`define EV_IC_REFILL_L2 12'h082
`define EV_IC_REFILL_SYS 12'h083
`define EV_ITB_L1M_L2H 12'h084

// Mask bit positions by mask value
`define UM_01H 0
`define UM_02H 1
`define UM_04H 2
`define UM_08H 3
`define UM_10H 4
`define UM_20H 5
`define UM_80H 7

`endif

// ===== hw/perf_sel_pkg.sv
// Purpose: Types shared by the event selector files
// Assumes: Constants come from perf_sel_cfg.svh
// Notes: State of the top module is a single packed struct
package perf_sel_pkg;

    typedef logic [7:0] event_vec_t;
    typedef logic [3:0] count_t;
    typedef logic [11:0] code_t;
    typedef logic [7:0] mask_t;
    typedef logic [31:0] word_t;

    typedef struct packed {
        logic enable;
        code_t event_code;
        mask_t sub_event_mask;
        word_t total;
        count_t increment;
        word_t prdata;
        logic pslverr;
    } sel_state_t;

endpackage

// ===== hw/event_mask_count.sv
// Purpose: Counts the strobes of a candidate vector that their enables admit
// Assumes: All strobes of one cycle are independent occurrences
// Notes: Purely combinational; the caller registers the result
module event_mask_count (
    // Candidate strobes and their enables
    input wire perf_sel_pkg::event_vec_t strobes,
    input wire perf_sel_pkg::event_vec_t enables,
    // Number of admitted strobes
    output perf_sel_pkg::count_t count
);

    perf_sel_pkg::count_t partial [0:8];

    assign partial[0] = 4'h0;

    // Running sum over the bits; every admitted bit adds one in this cycle
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_sum
            assign partial[i + 1] = partial[i] + {3'h0, strobes[i] & enables[i]};
        end
    endgenerate

    assign count = partial[8];

endmodule

// ===== hw/perf_event_select.sv
// Purpose: Event code and sub-event mask select which core strobes advance a counter
// Assumes: Event strobes are single-cycle and synchronous to clk (200 MHz)
// Notes: APB slave with zero wait states; an internal total shows the selected count
// Function
// - 04Dh counts L1 data TLB hits by page size
// - 052h counts software prefetches hitting L1 or L2
// - 054h counts flushes of global TLB entries
// - 065h counts uncacheable, combining and streaming requests
// - Combining events count buffer flushes, not stores
// - 067h mask selects cancels and prefetch attempts
// - 067h always counts zero on this device
// - 06Ch counts refill lines per coherency state
// - 06Dh counts 16-byte outbound transfers, up to four
// - 076h counts clocks while core not halted
// - 07Dh counts L2 read requests by source
// - 07Eh counts L2 misses by source
// - 07Fh counts L2 fills and L2 writebacks
// - Non-temporal line evictions never count as fills
// - 165h counts page size mismatches, later revisions
// - 080h counts instruction cache 16-byte fetches
// - 081h counts instruction cache misses
// - 082h counts instruction refills from L2
// - 083h counts instruction refills from system
// - 084h counts L1 miss, L2 hit instruction TLB
// - Instruction cache events count speculatively too
//
// Design decisions made here: the register addresses and the APB register port.
`include "perf_sel_cfg.svh"

module perf_event_select (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device revision level
    input wire logic later_revision,
    // Data translation buffer hits
    input wire logic data_translation_buffer_hit_4k,
    input wire logic data_translation_buffer_hit_2m,
    input wire logic data_translation_buffer_hit_1g,
    // Software prefetches satisfied in the core
    input wire logic sw_prefetch_l1_hit,
    input wire logic sw_prefetch_l2_hit,
    // Translation buffer flush of global entries
    input wire logic global_flush,
    // Memory requests by type
    input wire logic uncacheable_request,
    input wire logic write_combining_flush,
    input wire logic flush_from_streaming,
    // Refill lines returned by the system interface
    input wire logic refill_line_exclusive,
    input wire logic refill_line_modified,
    input wire logic refill_line_shared,
    input wire logic refill_line_owned,
    input wire logic refill_line_error,
    // Outbound 16-byte transfers in this cycle, 0 to 4
    input wire logic [2:0] octword_count,
    // Halt state
    input wire logic core_halted,
    input wire logic stop_clock_request,
    // L2 read requests
    input wire logic l2_req_instr_fill,
    input wire logic l2_req_data_fill,
    input wire logic l2_req_table_walk,
    input wire logic l2_req_tag_snoop,
    input wire logic l2_req_cancelled,
    input wire logic l2_req_hw_prefetch,
    // L2 misses
    input wire logic l2_miss_instr_fill,
    input wire logic l2_miss_data_fill,
    input wire logic l2_miss_table_walk,
    input wire logic l2_miss_hw_prefetch,
    // L2 fills and writebacks
    input wire logic l2_fill_l1_victim,
    input wire logic victim_nontemporal_prefetch,
    input wire logic l2_fill_table_walk,
    input wire logic l2_fill_prefetch,
    input wire logic l2_writeback_line,
    // Page size mismatches under nested paging
    input wire logic mismatch_guest_larger,
    input wire logic mismatch_memory_range_type_regs,
    input wire logic mismatch_host_larger,
    // Instruction cache and translation events
    input wire logic icache_fetch,
    input wire logic icache_miss,
    input wire logic icache_refill_l2,
    input wire logic icache_refill_system,
    input wire logic instr_translation_buffer_l1_miss_l2_hit,
    // Selected increment of the current cycle, registered
    output logic [3:0] increment,
    output logic count_enabled
);

    perf_sel_pkg::sel_state_t state;
    perf_sel_pkg::sel_state_t next_state;
    perf_sel_pkg::event_vec_t cand;
    perf_sel_pkg::event_vec_t admit;
    perf_sel_pkg::count_t sel_count;
    perf_sel_pkg::mask_t m;
    logic setup_phase;
    logic access_phase;
    logic addr_known;
    logic non_temporal_safe_fill;

    assign m = state.sub_event_mask;

    // Victims from non-temporal lines go to memory or are dropped, not into L2
    assign non_temporal_safe_fill = l2_fill_l1_victim & ~victim_nontemporal_prefetch;

    // Strobe and enable selection per event code; enables use only defined mask bits
    always_comb begin
        cand = 8'h00;
        admit = 8'h00;
        case (state.event_code)
            `EV_DTB_L1_HIT: begin
                cand[0] = data_translation_buffer_hit_4k;
                cand[1] = data_translation_buffer_hit_2m;
                cand[2] = data_translation_buffer_hit_1g;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_04H];
            end
            `EV_SW_PF_INEFF: begin
                cand[0] = sw_prefetch_l1_hit;
                cand[1] = sw_prefetch_l2_hit;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_08H];
            end
            `EV_GLOBAL_FLUSH: begin
                cand[0] = global_flush;
                admit[0] = 1'b1;
            end
            `EV_MEM_REQ_TYPE: begin
                // Flush strobes, so a filled buffer counts once however many stores
                cand[0] = uncacheable_request;
                cand[1] = write_combining_flush;
                cand[2] = write_combining_flush & flush_from_streaming;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_80H];
            end
            `EV_DATA_PF: begin
                // Prefetcher fills the data cache here, so neither sub-event occurs
                cand[0] = 1'b0;
                cand[1] = 1'b0;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
            end
            `EV_NB_READ_RESP: begin
                cand[0] = refill_line_exclusive;
                cand[1] = refill_line_modified;
                cand[2] = refill_line_shared;
                cand[3] = refill_line_owned;
                cand[4] = refill_line_error;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_04H];
                admit[3] = m[`UM_08H];
                admit[4] = m[`UM_10H];
            end
            `EV_OCTWORD_WR: begin
                // Thermometer code turns the transfer count into that many strobes
                cand[0] = (octword_count >= 3'h1);
                cand[1] = (octword_count >= 3'h2);
                cand[2] = (octword_count >= 3'h3);
                cand[3] = (octword_count >= 3'h4);
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_01H];
                admit[2] = m[`UM_01H];
                admit[3] = m[`UM_01H];
            end
            `EV_CLK_NOT_HALT: begin
                cand[0] = ~core_halted & ~stop_clock_request;
                admit[0] = 1'b1;
            end
            `EV_L2_REQ: begin
                // Retries show up as repeated request strobes and are counted
                cand[0] = l2_req_instr_fill;
                cand[1] = l2_req_data_fill;
                cand[2] = l2_req_table_walk;
                cand[3] = l2_req_tag_snoop;
                cand[4] = l2_req_cancelled;
                cand[5] = l2_req_hw_prefetch;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_04H];
                admit[3] = m[`UM_08H];
                admit[4] = m[`UM_10H];
                admit[5] = m[`UM_20H];
            end
            `EV_L2_MISS: begin
                cand[0] = l2_miss_instr_fill;
                cand[1] = l2_miss_data_fill;
                cand[2] = l2_miss_table_walk;
                cand[3] = l2_miss_hw_prefetch;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_04H];
                admit[3] = m[`UM_08H];
            end
            `EV_L2_FILL_WB: begin
                // Three fill sources share one mask bit and may coincide
                cand[0] = non_temporal_safe_fill;
                cand[1] = l2_writeback_line;
                cand[2] = l2_fill_table_walk;
                cand[3] = l2_fill_prefetch;
                admit[0] = m[`UM_01H];
                admit[1] = m[`UM_02H];
                admit[2] = m[`UM_01H];
                admit[3] = m[`UM_01H];
            end
            `EV_PAGE_MISMATCH: begin
                // Reserved on the early revision, so nothing is admitted there
                cand[0] = mismatch_guest_larger;
                cand[1] = mismatch_memory_range_type_regs;
                cand[2] = mismatch_host_larger;
                admit[0] = m[`UM_01H] & later_revision;
                admit[1] = m[`UM_02H] & later_revision;
                admit[2] = m[`UM_04H] & later_revision;
            end
            // Instruction side strobes are raw fetch activity, wrong paths included
            `EV_IC_FETCH: begin
                cand[0] = icache_fetch;
                admit[0] = 1'b1;
            end
            `EV_IC_MISS: begin
                cand[0] = icache_miss;
                admit[0] = 1'b1;
            end
            `EV_IC_REFILL_L2: begin
                cand[0] = icache_refill_l2;
                admit[0] = 1'b1;
            end
            `EV_IC_REFILL_SYS: begin
                cand[0] = icache_refill_system;
                admit[0] = 1'b1;
            end
            `EV_ITB_L1M_L2H: begin
                cand[0] = instr_translation_buffer_l1_miss_l2_hit;
                admit[0] = 1'b1;
            end
            default: begin
                // Unknown code: nothing advances
                cand = 8'h00;
                admit = 8'h00;
            end
        endcase
        if (!state.enable) begin
            admit = 8'h00;
        end
    end

    // Adds every admitted sub-event of this cycle
    event_mask_count u_count (
        .strobes(cand),
        .enables(admit),
        .count(sel_count)
    );

    // APB phase decode
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign addr_known = (paddr == `ADDR_SELECT) | (paddr == `ADDR_TOTAL) |
                        (paddr == `ADDR_STATUS);

    // Next state: register writes, read capture in setup, total accumulation
    always_comb begin
        next_state = state;
        next_state.increment = sel_count;
        next_state.total = state.total + {28'h0000000, sel_count};
        // Read data and error are latched in setup so the access phase needs no wait
        if (setup_phase) begin
            next_state.pslverr = ~addr_known;
            next_state.prdata = `RST_WORD;
            if (!pwrite) begin
                if (paddr == `ADDR_SELECT) begin
                    next_state.prdata[`SEL_CODE_MSB:`SEL_CODE_LSB] = state.event_code;
                    next_state.prdata[`SEL_MASK_MSB:`SEL_MASK_LSB] = state.sub_event_mask;
                    next_state.prdata[`SEL_EN_BIT] = state.enable;
                end else if (paddr == `ADDR_TOTAL) begin
                    next_state.prdata = state.total;
                end else if (paddr == `ADDR_STATUS) begin
                    next_state.prdata[`STAT_INC_MSB:`STAT_INC_LSB] = state.increment;
                    next_state.prdata[`STAT_REV_BIT] = later_revision;
                end
            end
        end
        // Writes take effect at the access edge only
        if (access_phase && pwrite) begin
            if (paddr == `ADDR_SELECT) begin
                next_state.event_code = pwdata[`SEL_CODE_MSB:`SEL_CODE_LSB];
                next_state.sub_event_mask = pwdata[`SEL_MASK_MSB:`SEL_MASK_LSB];
                next_state.enable = pwdata[`SEL_EN_BIT];
            end else if (paddr == `ADDR_TOTAL) begin
                // Clear keeps this cycle's events so none are lost
                next_state.total = {28'h0000000, sel_count};
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state.enable <= `RST_EN;
            state.event_code <= `RST_CODE;
            state.sub_event_mask <= `RST_MASK;
            state.total <= `RST_TOTAL;
            state.increment <= `RST_INC;
            state.prdata <= `RST_WORD;
            state.pslverr <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign prdata = state.prdata;
    assign pslverr = state.pslverr & access_phase;
    assign pready = 1'b1; // Zero wait states
    assign increment = state.increment;
    assign count_enabled = state.enable;

endmodule

// ===== testbench/perf_event_select_monitor.sv
// Purpose: Port assertions for the event selector
// Assumes: One clock domain, reset asynchronous and active low
// Notes: Shadows SELECT from APB writes so code-specific checks know the choice
module perf_event_select_monitor (
    // Clock, reset and APB
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Event side
    input wire logic later_revision,
    input wire logic [2:0] octword_count,
    input wire logic core_halted,
    input wire logic stop_clock_request,
    input wire logic [3:0] increment,
    input wire logic count_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sel;
    logic [11:0] code;
    logic on;
    logic mapped;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Shadow updates on the same edge as the register, so it is the pre-edge choice
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel <= 32'h0000_0000;
        end else if (psel && penable && pwrite && paddr == 12'h000) begin
            sel <= pwdata;
        end
    end
    assign code = sel[11:0];
    assign on = sel[31];
    assign mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;

    ready_always_a: assert property (pready) else $error("pready low");
    err_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    unmapped_err_a: assert property ((psel && !penable && !mapped) ##1 (psel && penable)
        |-> pslverr) else $error("unmapped access not refused");
    mapped_ok_a: assert property ((psel && !penable && mapped) ##1 (psel && penable)
        |-> !pslverr) else $error("mapped access refused");
    disabled_quiet_a: assert property (!count_enabled |=> increment == 4'h0)
        else $error("count while disabled");
    halted_quiet_a: assert property (on && code == 12'h076 &&
        (core_halted || stop_clock_request) |=> increment == 4'h0)
        else $error("count while halted");
    running_count_a: assert property (on && code == 12'h076 && !core_halted &&
        !stop_clock_request |=> increment == 4'h1) else $error("running clock missed");
    prefetcher_zero_a: assert property (on && code == 12'h067 |=> increment == 4'h0)
        else $error("prefetcher event counted");
    revision_gate_a: assert property (on && code == 12'h165 && !later_revision
        |=> increment == 4'h0) else $error("mismatch counted on early revision");
    octword_sum_a: assert property (on && code == 12'h06D && sel[16] |=> increment ==
        ($past(octword_count) > 3'h4 ? 4'h4 : {1'b0, $past(octword_count)}))
        else $error("octword count wrong");
    increment_max_a: assert property (increment <= 4'h6) else $error("increment too big");

    cover property (on && code == 12'h06D && octword_count == 3'h4);
    cover property ((psel && !penable && !mapped) ##1 pslverr);
    cover property (on && code == 12'h076 && !core_halted && !stop_clock_request);
endmodule

// ===== testbench/event_source_model.sv
// Purpose: Stand-in for the cache, TLB and system-interface event sources
// Assumes: raw changes just after a rising edge
// Notes: Quiet drives no strobes and holds the core halted
module event_source_model (
    // Raw pattern and silence request
    input wire logic [41:0] raw,
    input wire logic quiet,
    // Shaped event vector
    output logic [41:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    // Qualifiers only ride on their own strobe, and counts stay in range
    always_comb begin
        ev = quiet ? 42'h000_0000_4000 : raw;
        ev[8] = ev[8] & ev[7];
        ev[27] = ev[27] & ev[26];
        if (ev[41:39] > 3'h4) begin
            ev[41:39] = 3'h4;
        end
    end
endmodule

// ===== testbench/perf_event_select_tb.sv
// Purpose: Self-checking bench for the event selector
// Assumes: Zero-wait APB slave, increment one cycle after the strobes
// Notes: Reads TOTAL only while quiet, as it is then stable
module perf_event_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic later_revision = 1'b0;
    logic quiet = 1'b1;
    logic [41:0] raw = 42'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic count_enabled;
    logic [3:0] increment;
    logic [41:0] ev;
    logic [31:0] lfsr_state = 32'h19EE_3A37;
    logic [31:0] m_sel = 32'h0;
    logic [31:0] m_total = 32'h0;
    int exp_inc = 0;
    int error_cnt = 0;
    int samples_checked = 0;
    // Bit 30 is unused by the design and carries the revision level here
    logic [31:0] tab [22] = '{
        32'h8007_004D, 32'h8009_0052, 32'h80FF_0054,
        32'h8083_0065, 32'h8080_0065, 32'h8002_0065,
        32'h80FF_0067, 32'h801F_006C, 32'h8001_006D,
        32'h8000_0076, 32'h803F_007D, 32'h800F_007E,
        32'h8003_007F, 32'hC007_0165, 32'h8007_0165,
        32'h8000_0080, 32'h8000_0081, 32'h8000_0082,
        32'h8000_0083, 32'h8000_0084, 32'h80F8_0099,
        32'h0007_004D};

    always #2.5 clk = ~clk;

    event_source_model u_src (.raw(raw), .quiet(quiet), .ev(ev));

    perf_event_select u_dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .later_revision(later_revision),
        .data_translation_buffer_hit_4k(ev[0]), .data_translation_buffer_hit_2m(ev[1]),
        .data_translation_buffer_hit_1g(ev[2]), .sw_prefetch_l1_hit(ev[3]),
        .sw_prefetch_l2_hit(ev[4]), .global_flush(ev[5]), .uncacheable_request(ev[6]),
        .write_combining_flush(ev[7]), .flush_from_streaming(ev[8]),
        .refill_line_exclusive(ev[9]), .refill_line_modified(ev[10]),
        .refill_line_shared(ev[11]), .refill_line_owned(ev[12]), .refill_line_error(ev[13]),
        .core_halted(ev[14]), .stop_clock_request(ev[15]), .l2_req_instr_fill(ev[16]),
        .l2_req_data_fill(ev[17]), .l2_req_table_walk(ev[18]), .l2_req_tag_snoop(ev[19]),
        .l2_req_cancelled(ev[20]), .l2_req_hw_prefetch(ev[21]), .l2_miss_instr_fill(ev[22]),
        .l2_miss_data_fill(ev[23]), .l2_miss_table_walk(ev[24]),
        .l2_miss_hw_prefetch(ev[25]), .l2_fill_l1_victim(ev[26]),
        .victim_nontemporal_prefetch(ev[27]), .l2_fill_table_walk(ev[28]),
        .l2_fill_prefetch(ev[29]), .l2_writeback_line(ev[30]),
        .mismatch_guest_larger(ev[31]), .mismatch_memory_range_type_regs(ev[32]),
        .mismatch_host_larger(ev[33]), .icache_fetch(ev[34]), .icache_miss(ev[35]),
        .icache_refill_l2(ev[36]), .icache_refill_system(ev[37]),
        .instr_translation_buffer_l1_miss_l2_hit(ev[38]), .octword_count(ev[41:39]),
        .increment(increment), .count_enabled(count_enabled));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference count of one cycle from the choice and the strobes
    function automatic int model(input logic [31:0] s, input logic [41:0] e, input logic rev);
        logic [7:0] m;
        m = s[23:16];
        if (!s[31]) return 0;
        case (s[11:0])
            12'h04D: return $countones(m[2:0] & e[2:0]);
            12'h052: return int'(m[0] & e[3]) + int'(m[3] & e[4]);
            12'h054: return int'(e[5]);
            12'h065: return int'(m[0] & e[6]) + int'(m[1] & e[7]) + int'(m[7] & e[8]);
            12'h06C: return $countones(m[4:0] & e[13:9]);
            12'h06D: return m[0] ? int'(e[41:39]) : 0;
            12'h076: return int'(!e[14] && !e[15]);
            12'h07D: return $countones(m[5:0] & e[21:16]);
            12'h07E: return $countones(m[3:0] & e[25:22]);
            12'h07F: return int'(m[0]) * (int'(e[26] & !e[27]) + int'(e[28]) + int'(e[29]))
                + int'(m[1] & e[30]);
            12'h165: return rev ? $countones(m[2:0] & e[33:31]) : 0;
            12'h080, 12'h081, 12'h082, 12'h083, 12'h084: return int'(e[34 + s[2:0]]);
            default: return 0;
        endcase
    endfunction

    task automatic results();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_inc(input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Each edge: check last prediction, predict from pre-edge inputs, then new stimulus
    always @(posedge clk) begin
        if (arst_n) begin
            chk_inc(4'(exp_inc), increment);
            chk_inc({3'h0, m_sel[31]}, {3'h0, count_enabled});
        end
        exp_inc = model(m_sel, ev, later_revision);
        if (psel && penable && pwrite && paddr == 12'h004) begin
            m_total = 32'(exp_inc);
        end else begin
            m_total += 32'(exp_inc);
        end
        if (psel && penable && pwrite && paddr == 12'h000) begin
            m_sel = pwdata & 32'h80FF_0FFF;
        end
        lfsr_state = lfsr(lfsr_state);
        raw <= {lfsr_state[31:22] ^ lfsr_state[9:0], lfsr_state};
    end

    initial begin
        logic [31:0] rd;
        logic err;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 12'(a), 32'h0, rd, err);
            chk_word(32'h0000_0000, rd);
        end
        foreach (tab[i]) begin
            later_revision <= tab[i][30];
            quiet <= 1'b0;
            apb(1'b1, 12'h004, 32'h0, rd, err);
            apb(1'b1, 12'h000, tab[i], rd, err);
            repeat (60) @(posedge clk);
            apb(1'b0, 12'h000, 32'h0, rd, err);
            chk_word(tab[i] & 32'h80FF_0FFF, rd);
            quiet <= 1'b1;
            apb(1'b1, 12'h000, 32'h0, rd, err);
            repeat (3) @(posedge clk);
            apb(1'b0, 12'h004, 32'h0, rd, err);
            chk_word(m_total, rd);
            $display("test %0d select %h done", i, tab[i]);
        end
        // Refused and read-only places
        apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd, err);
        chk_word(32'h1, {31'h0, err});
        apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, err);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk_word({23'h0, later_revision, 8'h00}, rd);
        apb(1'b0, 12'h000, 32'h0, rd, err);
        chk_word(32'h0000_0000, rd);
        $display("test refusals done");
        results();
    end
endmodule

bind perf_event_select perf_event_select_monitor u_mon (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .later_revision(later_revision), .octword_count(octword_count),
    .core_halted(core_halted), .stop_clock_request(stop_clock_request),
    .increment(increment), .count_enabled(count_enabled));
